// [hw/irqef_ctrl.sv]
/*
 * request latches, request enables, interrupt pin control and the
 * contactless fault flags, reached over an Avalon-MM slave.
 * assumes every event input is a one-cycle pulse from logic on
 * ref_clk_i; the byte address is 4 * register index.
 */
`timescale 1ns/1ps
`include "irqef_params.svh"

module irqef_ctrl (
    // clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_n_i,
    // avalon-mm slave
    input  wire irqef_pkg::irqef_addr_t avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire irqef_pkg::irqef_word_t avs_writedata_i,
    output logic [31:0]               avs_readdata_o,
    output logic                      avs_waitrequest_o,
    // request sources, one-cycle pulses
    input  wire logic [6:0]           src_a_i,
    input  wire logic [5:0]           src_b_i,
    // fifo and command events
    input  wire logic                 nvm_done_i,
    input  wire logic                 nvm_err_i,
    input  wire logic                 fifo_wr_i,
    input  wire logic                 fifo_full_i,
    input  wire logic                 fifo_empty_i,
    input  wire logic                 crc_send_i,
    input  wire logic                 auth_cmd_i,
    input  wire irqef_pkg::irqef_com_t com_state_i,
    input  wire logic                 cmd_start_i,
    input  wire logic                 rx_cmd_start_i,
    input  wire logic                 flags_to_fifo_i,
    input  wire logic                 send_need_i,
    // receive decoder events
    input  wire logic                 frame_end_i,
    input  wire irqef_pkg::irqef_byte_t frame_bits_i,
    input  wire irqef_pkg::irqef_byte_t frame_bytes_i,
    input  wire logic                 coll_i,
    input  wire logic                 coll_in_eof_i,
    input  wire irqef_pkg::irqef_byte_t coll_pos_i,
    input  wire logic                 stop_bit_err_i,
    input  wire logic                 frame_mark_err_i,
    input  wire logic                 byte_cnt_err_i,
    input  wire logic                 parity_err_i,
    input  wire logic                 crc_err_i,
    // decoder and fifo controls
    output logic                      fifo_wr_ok_o,
    output logic                      frame_discard_o,
    output logic                      rx_stop_o,
    output logic                      drop_last_o,
    // interrupt pin, open-drain capable
    output logic                      irq_o,
    output logic                      irq_oe_n_o
);
    import irqef_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // registers

    irqef_bus_t  bus_reg;
    logic [31:0] rdata_reg;
    logic        wait_reg;
    irqef_byte_t en_a_reg;
    irqef_byte_t en_b_reg;
    irqef_byte_t fault_reg;
    irqef_byte_t fault_next;
    logic [6:0]  req_a_reg;
    logic [5:0]  req_b_reg;
    logic [6:0]  req_a_next;
    logic [5:0]  req_b_next;
    irqef_byte_t coll_reg;
    logic        collision_as_fault_reg;
    logic [1:0]  mode_reg;
    logic        comb_reg;
    logic        pin_reg;
    logic        oe_n_reg;
    logic        wrok_reg;
    logic        disc_reg;
    logic        stop_reg;
    logic        drop_reg;
    irqef_com_t  cs_reg;

    logic        wr_take;
    logic        rx_clear;
    logic        wr_busy;
    logic        short_frame;
    logic        discard;
    logic        prot_ev;
    logic        coll_ev;
    logic        comb_now;
    logic        level;
    logic [5:0]  idx;

    assign idx     = avs_address_i[5:0] >> 2;
    assign wr_take = avs_write_i && (bus_reg == IRQEF_ACK);

    ////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, then the access is taken

    // wait low one cycle after a request, readdata set the same edge
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_reg <= IRQEF_IDLE;
        end else begin
            case (bus_reg)
                IRQEF_IDLE: begin
                    if (avs_read_i || avs_write_i) begin
                        bus_reg <= IRQEF_ACK;
                    end
                end
                IRQEF_ACK: bus_reg <= IRQEF_IDLE;
                default:   bus_reg <= IRQEF_IDLE;
            endcase
        end
    end

    // read mux; unmapped words read as zero
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read_i && bus_reg == IRQEF_IDLE) begin
            case (idx)
                `IRQEF_IDX_REQ_A: rdata_reg <= {25'h0, req_a_reg};
                `IRQEF_IDX_REQ_B:
                    rdata_reg <= {25'h0, comb_reg, req_b_reg};
                `IRQEF_IDX_EN_A:  rdata_reg <= {24'h0, en_a_reg};
                `IRQEF_IDX_EN_B:  rdata_reg <= {24'h0, en_b_reg};
                `IRQEF_IDX_FAULT: rdata_reg <= {24'h0, fault_reg};
                `IRQEF_IDX_RXBIT: rdata_reg <= {28'h0, collision_as_fault_reg, 3'h0};
                `IRQEF_IDX_COLL:  rdata_reg <= {24'h0, coll_reg};
                `IRQEF_IDX_MODE:  rdata_reg <= {30'h0, mode_reg};
                default:          rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // waitrequest has its own flop so the pin needs no decode gate
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !(bus_reg == IRQEF_IDLE
                          && (avs_read_i || avs_write_i));
        end
    end

    assign avs_readdata_o    = rdata_reg;
    assign avs_waitrequest_o = wait_reg;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_a_reg   <= `IRQEF_EN_RST;
            en_b_reg   <= `IRQEF_EN_RST;
            collision_as_fault_reg <= 1'b0;
            mode_reg   <= 2'h0;
        end else if (wr_take) begin
            case (idx)
                `IRQEF_IDX_EN_A:  en_a_reg <= avs_writedata_i[7:0];
                `IRQEF_IDX_EN_B:  en_b_reg <= avs_writedata_i[7:0];
                `IRQEF_IDX_RXBIT:
                    collision_as_fault_reg <= avs_writedata_i[`IRQEF_COLLISION_AS_FAULT_BIT];
                `IRQEF_IDX_MODE:  mode_reg <= avs_writedata_i[1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // request latches

    // set or clear by written ones, sources win
    always_comb begin
        req_a_next = req_a_reg;
        req_b_next = req_b_reg;
        if (wr_take && idx == `IRQEF_IDX_REQ_A) begin
            if (avs_writedata_i[`IRQEF_SET_BIT]) begin
                req_a_next = req_a_reg | avs_writedata_i[6:0];
            end else begin
                req_a_next = req_a_reg & ~avs_writedata_i[6:0];
            end
        end
        if (wr_take && idx == `IRQEF_IDX_REQ_B) begin
            if (avs_writedata_i[`IRQEF_SET_BIT]) begin
                req_b_next = req_b_reg | avs_writedata_i[5:0];
            end else begin
                req_b_next = req_b_reg & ~avs_writedata_i[5:0];
            end
        end
        req_a_next[`IRQEF_RXREQ_BIT] = req_a_next[`IRQEF_RXREQ_BIT]
            | (src_a_i[`IRQEF_RXREQ_BIT] & ~discard);
        req_a_next = req_a_next
            | (src_a_i & ~(7'h01 << `IRQEF_RXREQ_BIT));
        req_a_next[`IRQEF_ERRREQ_BIT] = req_a_next[`IRQEF_ERRREQ_BIT]
            | fault_reg[`IRQEF_F_WR] | fault_reg[`IRQEF_F_OVR]
            | fault_reg[`IRQEF_F_PROT] | fault_reg[`IRQEF_F_EMPTY]
            | fault_reg[`IRQEF_F_INTEG];
        req_b_next = req_b_next | src_b_i;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_a_reg <= 7'h00;
            req_b_reg <= 6'h00;
        end else begin
            req_a_reg <= req_a_next;
            req_b_reg <= req_b_next;
        end
    end

    assign comb_now = |(req_a_reg & en_a_reg[6:0])
                    | |(req_b_reg & en_b_reg[5:0]);

    ////////////////////////////////////////////////////////////////////
    // interrupt pin

    assign level = (comb_now & en_b_reg[`IRQEF_FWD_BIT])
                 ^ en_a_reg[`IRQEF_INV_BIT];

    // registered so the pin never glitches on a decode
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            comb_reg <= 1'b0;
            pin_reg  <= 1'b0;
            oe_n_reg <= 1'b1;
        end else begin
            comb_reg <= comb_now;
            pin_reg  <= level;
            oe_n_reg <= ~(en_b_reg[`IRQEF_DRIVE_BIT] | ~level);
        end
    end

    assign irq_o      = pin_reg;
    assign irq_oe_n_o = oe_n_reg;

    ////////////////////////////////////////////////////////////////////
    // fault flags

    // receive start: receive command or entry to wait-for-data
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_reg <= 3'h0;
        end else begin
            cs_reg <= com_state_i;
        end
    end
    assign rx_clear = rx_cmd_start_i
        | (com_state_i == `IRQEF_CS_WAITDATA
           && cs_reg != `IRQEF_CS_WAITDATA);

    assign wr_busy = crc_send_i | auth_cmd_i
        | com_state_i == `IRQEF_CS_RXWAIT
        | com_state_i == `IRQEF_CS_WAITDATA
        | com_state_i == `IRQEF_CS_RECEIVING;

    assign short_frame = frame_end_i && frame_bits_i < `IRQEF_MIN_BITS;
    assign discard = short_frame || (frame_end_i
        && mode_reg[`IRQEF_SUPP_BIT] && frame_bytes_i < `IRQEF_MIN_BYTES);
    assign coll_ev = coll_i && !coll_in_eof_i;
    assign prot_ev = stop_bit_err_i | frame_mark_err_i | byte_cnt_err_i;

    // clears first, then sets, so an event never gets lost
    always_comb begin
        fault_next = fault_reg;
        if (mode_reg[`IRQEF_MULTI_BIT] ? flags_to_fifo_i : cmd_start_i) begin
            fault_next[`IRQEF_F_WR] = 1'b0;
        end
        if (cmd_start_i) begin
            fault_next[`IRQEF_F_OVR]   = 1'b0;
            fault_next[`IRQEF_F_EMPTY] = 1'b0;
        end
        if (rx_clear) begin
            fault_next[`IRQEF_F_SHORT] = 1'b0;
            fault_next[`IRQEF_F_COLL]  = 1'b0;
            fault_next[`IRQEF_F_PROT]  = 1'b0;
            fault_next[`IRQEF_F_INTEG] = 1'b0;
        end
        if (nvm_done_i) begin
            fault_next[`IRQEF_F_NVM] = nvm_err_i;
        end
        if (fifo_wr_i && wr_busy) begin
            fault_next[`IRQEF_F_WR] = 1'b1;
        end
        if (fifo_wr_i && fifo_full_i) begin
            fault_next[`IRQEF_F_OVR] = 1'b1;
        end
        if (short_frame) begin
            fault_next[`IRQEF_F_SHORT] = 1'b1;
        end
        if (send_need_i && fifo_empty_i) begin
            fault_next[`IRQEF_F_EMPTY] = 1'b1;
        end
        if (coll_ev) begin
            fault_next[`IRQEF_F_COLL] = 1'b1;
        end
        if (prot_ev) begin
            fault_next[`IRQEF_F_PROT] = 1'b1;
        end
        if (parity_err_i || crc_err_i || (coll_ev && collision_as_fault_reg)) begin
            fault_next[`IRQEF_F_INTEG] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_reg <= `IRQEF_FLAG_RST;
        end else begin
            fault_reg <= fault_next;
        end
    end

    // first collision position, cleared per reception
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            coll_reg <= 8'h00;
        // a collision in the clearing cycle opens the new reception
        end else if (coll_ev
                     && (rx_clear || !fault_reg[`IRQEF_F_COLL])) begin
            coll_reg <= {coll_pos_i < `IRQEF_COLL_RANGE, coll_pos_i[6:0]};
        end else if (rx_clear) begin
            coll_reg <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decoder and fifo controls, one cycle after the event

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wrok_reg <= 1'b0;
            disc_reg <= 1'b0;
            stop_reg <= 1'b0;
            drop_reg <= 1'b0;
        end else begin
            // writes dropped while full or overrun
            wrok_reg <= fifo_wr_i && !fifo_full_i
                        && !fault_reg[`IRQEF_F_OVR];
            disc_reg <= discard;
            stop_reg <= prot_ev;
            drop_reg <= prot_ev;
        end
    end

    assign fifo_wr_ok_o    = wrok_reg;
    assign frame_discard_o = disc_reg;
    assign rx_stop_o       = stop_reg;
    assign drop_last_o     = drop_reg;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_prot_seen;
        prot_ev;
    endsequence

    sequence s_stop_out;
        rx_stop_o && drop_last_o && fault_reg[`IRQEF_F_PROT];
    endsequence

    a_pin_invert: assert property (
        !en_b_reg[`IRQEF_FWD_BIT] && $stable(en_b_reg) && $stable(en_a_reg)
        |=> irq_o == $past(en_a_reg[`IRQEF_INV_BIT]))
        else $error("pin polarity wrong while forwarding off");

    a_gate_a: assert property (
        (req_a_reg & en_a_reg[6:0]) != 7'h00 |=> comb_reg)
        else $error("enabled request a not combined");

    a_gate_b: assert property (
        (req_a_reg & en_a_reg[6:0]) == 7'h00
        && (req_b_reg & en_b_reg[5:0]) == 6'h00 |=> !comb_reg)
        else $error("combined set with nothing enabled");

    a_drive_mode: assert property (
        en_b_reg[`IRQEF_DRIVE_BIT] && $stable(en_b_reg) |=> !irq_oe_n_o)
        else $error("push-pull pin not driven");

    a_od_release: assert property (
        !irq_oe_n_o && !en_b_reg[`IRQEF_DRIVE_BIT] && $stable(en_b_reg)
        |-> !irq_o)
        else $error("open-drain drove high level");

    a_ovr_drop: assert property (
        fifo_wr_i && fifo_full_i |=> fault_reg[`IRQEF_F_OVR] ##1 !wrok_reg)
        else $error("overrun not flagged or write passed");

    a_short_drop: assert property (
        short_frame && !src_a_i[`IRQEF_RXREQ_BIT]
        && !req_a_reg[`IRQEF_RXREQ_BIT] && !(wr_take && idx ==
        `IRQEF_IDX_REQ_A) |=> !req_a_reg[`IRQEF_RXREQ_BIT] && disc_reg)
        else $error("short frame raised receive-done");

    a_prot_stop: assert property (
        s_prot_seen |=> s_stop_out)
        else $error("protocol fault did not stop reception");

    a_eof_coll: assert property (
        coll_i && coll_in_eof_i && !fault_reg[`IRQEF_F_COLL]
        |=> !fault_reg[`IRQEF_F_COLL])
        else $error("end-symbol collision set flag");

    a_err_req: assert property (
        fault_reg[`IRQEF_F_INTEG] |=> req_a_reg[`IRQEF_ERRREQ_BIT])
        else $error("fault did not raise error request");

    a_bus_ack: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o
        |-> ##[1:2] !avs_waitrequest_o)
        else $error("bus access never acknowledged");

endmodule : irqef_ctrl

// [hw/irqef_params.svh]
/*
 * register indices, field positions, reset values and state codes
 * for the request enable and contactless fault flag block.
 * assumes a 32-bit word per register: byte address = 4 * index.
 */
`ifndef IRQEF_PARAMS_SVH
`define IRQEF_PARAMS_SVH

// register indices
`define IRQEF_IDX_REQ_A       6'h06
`define IRQEF_IDX_REQ_B       6'h07
`define IRQEF_IDX_EN_A        6'h08
`define IRQEF_IDX_EN_B        6'h09
`define IRQEF_IDX_FAULT       6'h0a
`define IRQEF_IDX_RXBIT       6'h0c
`define IRQEF_IDX_COLL        6'h0d
`define IRQEF_IDX_MODE        6'h0e

// field positions
`define IRQEF_SET_BIT         7
`define IRQEF_INV_BIT         7
`define IRQEF_DRIVE_BIT       7
`define IRQEF_FWD_BIT         6
`define IRQEF_COMB_BIT        6
`define IRQEF_ERRREQ_BIT      1
`define IRQEF_RXREQ_BIT       2
`define IRQEF_F_NVM           7
`define IRQEF_F_WR            6
`define IRQEF_F_OVR           5
`define IRQEF_F_SHORT         4
`define IRQEF_F_EMPTY         3
`define IRQEF_F_COLL          2
`define IRQEF_F_PROT          1
`define IRQEF_F_INTEG         0
`define IRQEF_COLLISION_AS_FAULT_BIT      3
`define IRQEF_MULTI_BIT       0
`define IRQEF_SUPP_BIT        1

// reset values
`define IRQEF_EN_RST          8'h00
`define IRQEF_FLAG_RST        8'h00

// frame limits and collision range
`define IRQEF_MIN_BITS        8'h04
`define IRQEF_MIN_BYTES       8'h03
`define IRQEF_COLL_RANGE      8'h40

// transceiver state codes
`define IRQEF_CS_RXWAIT       3'h5
`define IRQEF_CS_WAITDATA     3'h6
`define IRQEF_CS_RECEIVING    3'h7

`endif

// [hw/irqef_pkg.sv]
/*
 * types shared by the request enable and fault flag block.
 * assumes the constants header is included where numbers are needed.
 */
package irqef_pkg;
    typedef logic [7:0]  irqef_byte_t;
    typedef logic [2:0]  irqef_com_t;
    typedef logic [31:0] irqef_word_t;
    typedef logic [5:0]  irqef_addr_t;
    // slave handshake phases
    typedef enum logic {
        IRQEF_IDLE,
        IRQEF_ACK
    } irqef_bus_t;
endpackage : irqef_pkg

// [verif/irqef_host.sv]
/* host model: avalon-mm master tasks and the pulled-up request line.
   assumes one clock shared with the block and an idle-high pin. */
`timescale 1ns/1ps
module irqef_host (
    // clock
    input  wire logic        ref_clk_i,
    // avalon-mm master
    output logic [5:0]       address_o,
    output logic             read_o,
    output logic             write_o,
    output logic [31:0]      writedata_o,
    input  wire logic [31:0] readdata_i,
    input  wire logic        waitrequest_i,
    // interrupt pin
    input  wire logic        irq_i,
    input  wire logic        irq_oe_n_i,
    output logic             irq_line_o
);
    initial begin
        address_o   = '0;
        read_o      = 1'b0;
        write_o     = 1'b0;
        writedata_o = '0;
    end
    // released pin floats up through the pull-up, never shows old data
    assign irq_line_o = irq_oe_n_i ? 1'b1 : irq_i;
    ////////////////////////////////////////////////////////////////////
    // one access by register index; held until waitrequest is seen low
    // set bit in the written byte
    task automatic access(input logic w, input logic [5:0] idx,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk_i);
        address_o   <= 6'(idx << 2);
        writedata_o <= {24'h0, d};
        read_o      <= !w;
        write_o     <= w;
        do @(posedge ref_clk_i); while (waitrequest_i !== 1'b0);
        q = readdata_i[7:0];
        read_o  <= 1'b0;
        write_o <= 1'b0;
    endtask : access
endmodule : irqef_host

// [verif/tb.sv]
/* self-checking bench: pin gating with random sources, fault flags.
   assumes the host model and the block's constants header. */
`timescale 1ns/1ps
`include "irqef_params.svh"
module tb;
    import irqef_pkg::*;
    logic ref_clk_i = 0, rst_n_i = 0;
    logic [12:0] src = '0;
    logic [13:0] ev = '0;  // event pulses
    logic [4:0] lv = '0;   // full, empty, crc send, auth, eof collision
    logic [2:0] com = '0;
    logic [7:0] fbits = 8'h08, fbytes = 8'h05, cpos = 8'h05, rd;
    logic [5:0] adr;
    logic rdq, wrq, wt, irq, oe_n, line, pre, ok, dis, stp, drp;
    logic [31:0] wdat, rdat;
    logic [3:0] o;
    logic [2:0] cfg;
    logic [12:0] m;
    int num_errors = 0, tests_run = 0, s;
    always #25 ref_clk_i = ~ref_clk_i;
    irqef_ctrl u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(adr), .avs_read_i(rdq), .avs_write_i(wrq),
        .avs_writedata_i(wdat), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .src_a_i(src[6:0]), .src_b_i(src[12:7]),
        .nvm_done_i(ev[0]), .nvm_err_i(ev[1]), .fifo_wr_i(ev[2]),
        .fifo_full_i(lv[0]), .fifo_empty_i(lv[1]), .crc_send_i(lv[2]),
        .auth_cmd_i(lv[3]), .com_state_i(com), .cmd_start_i(ev[3]),
        .rx_cmd_start_i(ev[4]), .flags_to_fifo_i(ev[5]),
        .send_need_i(ev[6]), .frame_end_i(ev[7]), .frame_bits_i(fbits),
        .frame_bytes_i(fbytes), .coll_i(ev[8]), .coll_in_eof_i(lv[4]),
        .coll_pos_i(cpos), .stop_bit_err_i(ev[9]),
        .frame_mark_err_i(ev[10]), .byte_cnt_err_i(ev[11]),
        .parity_err_i(ev[12]), .crc_err_i(ev[13]), .fifo_wr_ok_o(ok),
        .frame_discard_o(dis), .rx_stop_o(stp), .drop_last_o(drp),
        .irq_o(irq), .irq_oe_n_o(oe_n));
    irqef_host u_host (.ref_clk_i(ref_clk_i), .address_o(adr),
        .read_o(rdq), .write_o(wrq), .writedata_o(wdat),
        .readdata_i(rdat), .waitrequest_i(wt), .irq_i(irq),
        .irq_oe_n_i(oe_n), .irq_line_o(line));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [5:0] i,
                       input logic [7:0] d);
        u_host.access(w, i, d, rd);
    endtask : acc
    // pulse request sources; pin settles two edges after the pulse
    task automatic pulse(input logic [12:0] v);
        @(posedge ref_clk_i);
        src <= v;
        @(posedge ref_clk_i);
        src <= '0;
        @(posedge ref_clk_i);
        #1;
    endtask : pulse
    // one event cycle; registered side outputs looked at one cycle on
    task automatic fire(input logic [13:0] e, input logic [4:0] l,
                        input logic [2:0] c);
        @(posedge ref_clk_i);
        ev  <= e;
        lv  <= l;
        com <= c;
        @(posedge ref_clk_i);
        ev  <= '0;
        lv  <= '0;
        #1 o = {ok, dis, stp, drp};
    endtask : fire
    // optional clear, one event, then side outputs and flags compared
    task automatic row(input logic k, input logic [13:0] e,
        input logic [4:0] l, input logic [2:0] c, input logic [7:0] f,
        input logic [3:0] msk, input logic [3:0] x);
        if (!k) fire(14'h0019, 5'h0, 3'h0);
        fire(e, l, c);
        chk({4'h0, o & msk}, {4'h0, x});
        acc(0, `IRQEF_IDX_FAULT, 8'h0);
        chk(rd, f);
        com <= '0;
    endtask : row
    task automatic give_verdict;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the several hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        give_verdict();
    end
    initial begin
        s = $urandom(32'h5423);
        repeat (8) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        chk({7'h0, line}, 8'h01);
        acc(0, `IRQEF_IDX_EN_A, 8'h0);
        chk(rd, `IRQEF_EN_RST);
        acc(0, `IRQEF_IDX_EN_B, 8'h0);
        chk(rd, `IRQEF_EN_RST);
        acc(0, 6'h0f, 8'h0);
        chk(rd, 8'h00);
        acc(1, `IRQEF_IDX_FAULT, 8'hff);
        acc(0, `IRQEF_IDX_FAULT, 8'h0);
        chk(rd, 8'h00);
        $display("test reset done");
        // random source, polarity, drive and forwarding per round
        for (int i = 0; i < 16; i++) begin
            s = $urandom_range(12, 0);
            cfg = 3'($urandom);
            if (i < 3) cfg[2] = 1'b1;
            m = 13'h1 << s;
            acc(1, `IRQEF_IDX_EN_A, {cfg[0], m[6:0]});
            acc(1, `IRQEF_IDX_EN_B, {cfg[1], cfg[2], m[12:7]});
            pulse(~m);
            pre = line;
            acc(0, `IRQEF_IDX_REQ_B, 8'h0);
            chk({7'h0, rd[6]}, 8'h00);
            pulse(m);
            if (cfg[2]) begin
                chk({7'h0, line}, {7'h0, ~cfg[0]});
                chk({7'h0, oe_n}, {7'h0, ~cfg[0] & ~cfg[1]});
            end else chk({7'h0, line}, {7'h0, pre});
            acc(0, `IRQEF_IDX_REQ_B, 8'h0);
            chk({7'h0, rd[6]}, 8'h01);
            acc(1, `IRQEF_IDX_REQ_A, 8'h7f);
            acc(1, `IRQEF_IDX_REQ_B, 8'h7f);
            acc(0, `IRQEF_IDX_REQ_B, 8'h0);
            chk({7'h0, rd[6]}, 8'h00);
        end
        $display("test pin done");
        row(0, 14'h0003, 5'h00, 3'h0, 8'h80, 4'h0, 4'h0);
        for (int c = 5; c < 8; c++)
            row(0, 14'h0004, 5'h00, 3'(c), 8'h40, 4'h0, 4'h0);
        row(0, 14'h0004, 5'h04, 3'h0, 8'h40, 4'h0, 4'h0);
        row(0, 14'h0004, 5'h08, 3'h0, 8'h40, 4'h0, 4'h0);
        acc(0, `IRQEF_IDX_REQ_A, 8'h0);
        chk(rd & 8'h02, 8'h02);
        row(1, 14'h0008, 5'h00, 3'h0, 8'h00, 4'h0, 4'h0);
        row(0, 14'h0004, 5'h00, 3'h0, 8'h00, 4'h8, 4'h8);
        row(0, 14'h0004, 5'h01, 3'h0, 8'h20, 4'h8, 4'h0);
        row(1, 14'h0004, 5'h00, 3'h0, 8'h20, 4'h8, 4'h0);
        fbits <= 8'h03;
        row(0, 14'h0080, 5'h00, 3'h0, 8'h10, 4'h4, 4'h4);
        fbits <= 8'h04;
        row(0, 14'h0080, 5'h00, 3'h0, 8'h00, 4'h4, 4'h0);
        row(0, 14'h0040, 5'h02, 3'h0, 8'h08, 4'h0, 4'h0);
        row(0, 14'h0040, 5'h00, 3'h0, 8'h00, 4'h0, 4'h0);
        cpos <= 8'($urandom_range(63, 0));
        row(0, 14'h0100, 5'h00, 3'h0, 8'h04, 4'h0, 4'h0);
        acc(0, `IRQEF_IDX_COLL, 8'h0);
        chk(rd, {1'b1, cpos[6:0]});
        row(0, 14'h0100, 5'h10, 3'h0, 8'h00, 4'h0, 4'h0);
        for (int b = 9; b < 12; b++)
            row(0, 14'h1 << b, 5'h0, 3'h0, 8'h02, 4'h3, 4'h3);
        row(0, 14'h1000, 5'h00, 3'h0, 8'h01, 4'h2, 4'h0);
        row(0, 14'h2000, 5'h00, 3'h0, 8'h01, 4'h2, 4'h0);
        acc(1, `IRQEF_IDX_RXBIT, 8'h08);
        row(0, 14'h0100, 5'h00, 3'h0, 8'h05, 4'h0, 4'h0);
        acc(1, `IRQEF_IDX_RXBIT, 8'h00);
        row(1, 14'h1200, 5'h00, 3'h0, 8'h07, 4'h0, 4'h0);
        row(1, 14'h0010, 5'h00, 3'h0, 8'h00, 4'h0, 4'h0);
        row(1, 14'h1200, 5'h00, 3'h0, 8'h03, 4'h0, 4'h0);
        row(1, 14'h0000, 5'h00, 3'h6, 8'h00, 4'h0, 4'h0);
        $display("test faults done");
        // multi-receive and disturbance suppression, then a second reset
        acc(1, `IRQEF_IDX_MODE, 8'h03);
        acc(0, `IRQEF_IDX_MODE, 8'h0);
        chk(rd, 8'h03);
        row(0, 14'h0004, 5'h00, 3'h5, 8'h40, 4'h0, 4'h0);
        row(1, 14'h0008, 5'h00, 3'h0, 8'h40, 4'h0, 4'h0);
        row(1, 14'h0020, 5'h00, 3'h0, 8'h00, 4'h0, 4'h0);
        fbytes <= 8'h02;
        row(0, 14'h0080, 5'h00, 3'h0, 8'h00, 4'h4, 4'h4);
        fbytes <= 8'h03;
        row(0, 14'h0080, 5'h00, 3'h0, 8'h00, 4'h4, 4'h0);
        acc(1, `IRQEF_IDX_EN_B, 8'hff);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        acc(0, `IRQEF_IDX_EN_B, 8'h0);
        chk(rd, `IRQEF_EN_RST);
        $display("test modes done");
        give_verdict();
    end
endmodule : tb
